// *** include/aux_readout_params.svh ***
// Constants of the overflow, look-at-me and auxiliary readout port
// What this block does
// - Overflow flags when any channel's bit 16, or bit 24 if selected, is one.
// - Auto load-and-clear switch fires load then clear when overflow arises.
// - Overflow request switch keeps look-at-me raised while overflow lasts.
// - Data-valid request switch raises look-at-me whenever readout register holds data.
// - Strobe S2 read clears it; set again 500 ns later until last channel.
// - Readout-enable request switch raises look-at-me after a readout request.
// - Test, clear and enable/disable look-at-me functions answer per dataway standard.
// - Respond only on module number match; 5-bit channel field picks channel.
// - After address strobe ends, drive the 24-bit count with data strobe.
// - Dataway reads win over aux reads; aux answer takes 500 to 900 ns.
// - A running test cycle holds off aux readout for 12.8 us.
// - Aux readout is suspended while the suspend bit is set.
// - Dataway initialize clears the suspend bit.
// - Unarmed readout or latching bypass loads the live counter value.
// - Veto-on-bus-read inhibits all counting 200 ns while loading output register.
// - Armed, unfinished dataway readout without latching bypass makes aux reads use latched values.
// - All aux bus lines are negative logic: low means one.
// - Data strobe accompanies data for 500 ns within 50 ns.
`ifndef AUX_READOUT_PARAMS_SVH
`define AUX_READOUT_PARAMS_SVH

`define CLK_MHZ 250
`define NS_TO_CYC(ns) (((ns) * `CLK_MHZ + 999) / 1000)

// Times in ns and their cycle counts
`define T_RESP_MIN_NS 500
`define T_VETO_NS 200
`define T_STROBE_NS 500
`define T_REARM_NS 500
`define T_TEST_HOLD_NS 12800
`define RESP_MIN_CYC `NS_TO_CYC(`T_RESP_MIN_NS)
`define VETO_CYC `NS_TO_CYC(`T_VETO_NS)
`define STROBE_CYC `NS_TO_CYC(`T_STROBE_NS)
`define REARM_CYC `NS_TO_CYC(`T_REARM_NS)
`define TEST_HOLD_CYC `NS_TO_CYC(`T_TEST_HOLD_NS)

// Register byte offsets
`define REG_CMD_OFS 8'h00
`define REG_SWITCH_OFS 8'h04
`define REG_STATUS_OFS 8'h08

// Field positions
`define CMD_SUSPEND_BIT 0
`define SW_WIDTH 11
`define ST_OVF_BIT 0
`define ST_LAM_BIT 1
`define ST_ARMED_BIT 2
`define ST_BUSY_BIT 3
`define ST_LAMEN_BIT 4
`define ST_HOLD_BIT 5

// Address word fields on the shared lines
`define ADDR_CHAN_LSB 0
`define ADDR_MOD_LSB 5

// Reset values
`define CMD_RST 1'b0
`define SWITCH_RST 11'h000

// Overflow bit indexes, counting from zero
`define OVF_BIT_NARROW 15
`define OVF_BIT_WIDE 23

`endif

// *** include/aux_readout_pkg.sv ***
// Types shared by the auxiliary readout design
package aux_readout_pkg;

  typedef enum logic [2:0] {
    AUX_IDLE,
    AUX_ADDR,
    AUX_WAIT,
    AUX_LOAD,
    AUX_DRIVE
  } aux_state_t;

  // Side switch settings, software-written
  typedef struct packed {
    logic [3:0] module_num;
    logic veto_on_bus_read;
    logic latching_bypass;
    logic request_on_readout_enable;
    logic request_on_data_valid;
    logic request_on_overflow;
    logic auto_load_clear_on_overflow;
    logic overflow_width_select;
  } switch_t;

  // Drive to the auxiliary bus pins
  typedef struct packed {
    logic [23:0] lines_n;
    logic lines_oe;
    logic strobe_oe;
  } bus_drive_t;

endpackage

// *** hdl/hold_timer.sv ***
// Down-counting hold timer
`timescale 1ns/1ps
module hold_timer #(
  parameter int W = 12
) (
  input wire logic i_clk_sys, // System clock
  input wire logic i_rst_n, // Asynchronous reset, active low
  input wire logic i_start, // Start pulse, reloads the count
  input wire logic [W-1:0] i_cycles, // Hold length in cycles
  output logic o_busy // High while counting
);

  logic [W-1:0] count_reg;

  // Reload on start, otherwise count to zero
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_reg <= '0;
    end else if (i_start) begin
      count_reg <= i_cycles;
    end else if (count_reg != '0) begin
      count_reg <= count_reg - W'(1);
    end
  end

  assign o_busy = (count_reg != '0);

endmodule

// *** hdl/aux_readout.sv ***
// Overflow, look-at-me and auxiliary bus readout logic of the scaler
//
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "aux_readout_params.svh"
module aux_readout (
  input wire logic i_clk_sys, // System clock, 250 MHz
  input wire logic i_rst_n, // Asynchronous reset, active low
  // AXI4-Lite slave
  input wire logic [7:0] i_awaddr, // Write address
  input wire logic i_awvalid, // Write address valid
  output logic o_awready, // Write address ready
  input wire logic [31:0] i_wdata, // Write data
  input wire logic [3:0] i_wstrb, // Write byte strobes
  input wire logic i_wvalid, // Write data valid
  output logic o_wready, // Write data ready
  output logic [1:0] o_bresp, // Write response
  output logic o_bvalid, // Write response valid
  input wire logic i_bready, // Write response ready
  input wire logic [7:0] i_araddr, // Read address
  input wire logic i_arvalid, // Read address valid
  output logic o_arready, // Read address ready
  output logic [31:0] o_rdata, // Read data
  output logic [1:0] o_rresp, // Read response
  output logic o_rvalid, // Read data valid
  input wire logic i_rready, // Read data ready
  // Scaler core
  input wire logic [31:0] i_chan_bit16, // Bit 16 of each channel
  input wire logic [31:0] i_chan_bit24, // Bit 24 of each channel
  input wire logic [23:0] i_chan_value, // Value of selected channel
  output logic [4:0] o_chan_sel, // Channel to present
  output logic o_use_latched, // Select latched over live value
  output logic o_veto, // Inhibit all counting
  output logic o_load_req, // Load function pulse
  output logic o_clear_req, // Clear function pulse
  // Dataway readout state and functions
  input wire logic i_dw_init, // Dataway initialize pulse
  input wire logic i_readout_armed, // Readout armed indicator
  input wire logic i_readout_init, // Readout initialized pulse
  input wire logic i_readout_done, // Last channel has been read
  input wire logic i_readout_request, // Readout request pulse
  input wire logic i_s2_read, // Read at strobe S2 pulse
  input wire logic i_dw_read_busy, // Dataway read in progress
  input wire logic i_test_start, // Test cycle start pulse
  input wire logic i_fn_test_lam, // Test look-at-me pulse
  input wire logic i_fn_clear_lam, // Clear look-at-me pulse
  input wire logic i_fn_enable_lam, // Enable look-at-me pulse
  input wire logic i_fn_disable_lam, // Disable look-at-me pulse
  output logic o_lam, // Look-at-me request
  output logic o_q, // Q answer to last function
  // Auxiliary bus, negative logic
  input wire logic [8:0] i_shared_bus_lines_n, // Address word in
  input wire logic i_address_strobe_n, // Address strobe in
  output logic [23:0] o_shared_bus_lines_n, // Data word out
  output logic o_shared_bus_lines_oe, // Data lines drive enable
  output logic o_data_valid_strobe_n, // Data strobe level when driven
  output logic o_data_valid_strobe_oe // Data strobe pull-down enable
);

  // ****************************************************************
  // Registers and bus slave
  // ****************************************************************

  logic command_word_register;
  aux_readout_pkg::switch_t switch_reg;
  logic [7:0] awaddr_reg;
  logic aw_held_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic w_held_reg;
  logic ovf_reg;
  logic lam_data_reg;
  logic lam_enable_reg;
  logic lam_pending;
  logic test_hold;
  aux_readout_pkg::aux_state_t aux_state_reg;
  aux_readout_pkg::bus_drive_t bus_reg;

  // Address match for a register offset
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr[7:2] == ofs[7:2]);
  endfunction

  logic do_write;
  assign do_write = aw_held_reg && w_held_reg && !o_bvalid;

  // Catch write address and data in either order
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else begin
      if (o_awready && i_awvalid) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= i_awaddr;
      end else if (do_write) begin
        aw_held_reg <= 1'b0;
      end
      if (o_wready && i_wvalid) begin
        w_held_reg <= 1'b1;
        wdata_reg <= i_wdata;
        wstrb_reg <= i_wstrb;
      end else if (do_write) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // Ready flags and write response
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_awready <= 1'b0;
      o_wready <= 1'b0;
      o_bvalid <= 1'b0;
      o_bresp <= 2'h0;
    end else begin
      o_awready <= !aw_held_reg && !(o_awready && i_awvalid) && !o_bvalid;
      o_wready <= !w_held_reg && !(o_wready && i_wvalid) && !o_bvalid;
      if (do_write) begin
        o_bvalid <= 1'b1;
        o_bresp <= (hit(awaddr_reg, `REG_CMD_OFS) || hit(awaddr_reg, `REG_SWITCH_OFS)
                    || hit(awaddr_reg, `REG_STATUS_OFS)) ? 2'h0 : 2'h2;
      end else if (i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // Command word; dataway initialize clears the suspend bit
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      command_word_register <= `CMD_RST;
    end else if (i_dw_init) begin
      command_word_register <= 1'b0;
    end else if (do_write && hit(awaddr_reg, `REG_CMD_OFS) && wstrb_reg[0]) begin
      command_word_register <= wdata_reg[`CMD_SUSPEND_BIT];
    end
  end

  // Side switch settings
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      switch_reg <= `SWITCH_RST;
    end else if (do_write && hit(awaddr_reg, `REG_SWITCH_OFS)) begin
      if (wstrb_reg[0]) switch_reg[7:0] <= wdata_reg[7:0];
      if (wstrb_reg[1]) switch_reg[`SW_WIDTH-1:8] <= wdata_reg[`SW_WIDTH-1:8];
    end
  end

  // Read channel, one cycle answer
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= 2'h0;
    end else begin
      o_arready <= !o_rvalid && !(o_arready && i_arvalid);
      if (o_arready && i_arvalid) begin
        o_rvalid <= 1'b1;
        o_rresp <= 2'h0;
        o_rdata <= 32'h0000_0000;
        if (hit(i_araddr, `REG_CMD_OFS)) begin
          o_rdata[`CMD_SUSPEND_BIT] <= command_word_register;
        end else if (hit(i_araddr, `REG_SWITCH_OFS)) begin
          o_rdata[`SW_WIDTH-1:0] <= switch_reg;
        end else if (hit(i_araddr, `REG_STATUS_OFS)) begin
          o_rdata[`ST_OVF_BIT] <= ovf_reg;
          o_rdata[`ST_LAM_BIT] <= lam_pending;
          o_rdata[`ST_ARMED_BIT] <= i_readout_armed;
          o_rdata[`ST_BUSY_BIT] <= (aux_state_reg != aux_readout_pkg::AUX_IDLE);
          o_rdata[`ST_LAMEN_BIT] <= lam_enable_reg;
          o_rdata[`ST_HOLD_BIT] <= test_hold;
        end else begin
          o_rresp <= 2'h2;
        end
      end else if (i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Overflow and automatic load and clear
  // ****************************************************************

  logic ovf_any;
  assign ovf_any = switch_reg.overflow_width_select ? (|i_chan_bit24) : (|i_chan_bit16);

  // Overflow flag and load-then-clear on its rising edge
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ovf_reg <= 1'b0;
      o_load_req <= 1'b0;
      o_clear_req <= 1'b0;
    end else begin
      ovf_reg <= ovf_any;
      o_load_req <= switch_reg.auto_load_clear_on_overflow && ovf_any && !ovf_reg;
      o_clear_req <= o_load_req;
    end
  end

  // ****************************************************************
  // Look-at-me request
  // ****************************************************************

  logic lam_rearm_reg;
  logic [7:0] rearm_cnt_reg;
  logic lam_readout_reg;

  // Data-valid source: cleared by S2 read, set again 500 ns later while armed and not done
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lam_data_reg <= 1'b0;
      lam_rearm_reg <= 1'b0;
      rearm_cnt_reg <= 8'h00;
    end else if (i_readout_init) begin
      lam_data_reg <= 1'b1;
      lam_rearm_reg <= 1'b0;
    end else if (i_dw_init || i_fn_clear_lam) begin
      lam_data_reg <= 1'b0;
      lam_rearm_reg <= 1'b0;
    end else if (i_s2_read) begin
      lam_data_reg <= 1'b0;
      lam_rearm_reg <= 1'b1;
      rearm_cnt_reg <= 8'(`REARM_CYC - 1);
    end else if (lam_rearm_reg) begin
      if (rearm_cnt_reg != 8'h00) begin
        rearm_cnt_reg <= rearm_cnt_reg - 8'h01;
      end else begin
        lam_rearm_reg <= 1'b0;
        lam_data_reg <= i_readout_armed && !i_readout_done;
      end
    end
  end

  // Readout-enable source, held until cleared
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lam_readout_reg <= 1'b0;
    end else if (i_readout_request) begin
      lam_readout_reg <= 1'b1;
    end else if (i_dw_init || i_fn_clear_lam) begin
      lam_readout_reg <= 1'b0;
    end
  end

  assign lam_pending = (switch_reg.request_on_overflow && ovf_reg)
                       || (switch_reg.request_on_data_valid && lam_data_reg)
                       || (switch_reg.request_on_readout_enable && lam_readout_reg);

  // Mask, request output and Q answers
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lam_enable_reg <= 1'b0;
      o_lam <= 1'b0;
      o_q <= 1'b0;
    end else begin
      if (i_dw_init || i_fn_disable_lam) begin
        lam_enable_reg <= 1'b0;
      end else if (i_fn_enable_lam) begin
        lam_enable_reg <= 1'b1;
      end
      o_lam <= lam_enable_reg && lam_pending;
      if (i_fn_test_lam) begin
        o_q <= lam_pending;
      end else if (i_fn_clear_lam || i_fn_enable_lam || i_fn_disable_lam) begin
        o_q <= 1'b1;
      end else begin
        o_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Auxiliary bus readout
  // ****************************************************************

  logic [8:0] addr_word_reg;
  logic [7:0] phase_cnt_reg, veto_cnt_reg;
  logic strobe_on;
  logic addr_match;

  // Test cycle hold-off timer
  hold_timer #(
    .W(12)
  ) u_test_hold (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_start(i_test_start),
    .i_cycles(12'(`TEST_HOLD_CYC)),
    .o_busy(test_hold)
  );

  assign strobe_on = !i_address_strobe_n;
  assign addr_match = (addr_word_reg[`ADDR_MOD_LSB +: 4] == switch_reg.module_num);

  // Transfer sequence: address, wait for a free slot, load, drive
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aux_state_reg <= aux_readout_pkg::AUX_IDLE;
      addr_word_reg <= 9'h000;
      phase_cnt_reg <= 8'h00;
      veto_cnt_reg <= 8'h00;
      o_chan_sel <= 5'h00;
      o_use_latched <= 1'b0;
      o_veto <= 1'b0;
      bus_reg <= '0;
    end else begin
      unique case (aux_state_reg)
        aux_readout_pkg::AUX_IDLE: begin
          if (strobe_on) begin
            aux_state_reg <= aux_readout_pkg::AUX_ADDR;
          end
        end
        aux_readout_pkg::AUX_ADDR: begin
          if (strobe_on) addr_word_reg <= ~i_shared_bus_lines_n;
          if (!strobe_on) begin
            aux_state_reg <= addr_match ? aux_readout_pkg::AUX_WAIT
                                        : aux_readout_pkg::AUX_IDLE;
            phase_cnt_reg <= 8'(`RESP_MIN_CYC - 1);
          end
        end
        aux_readout_pkg::AUX_WAIT: begin
          if (phase_cnt_reg != 8'h00) begin
            phase_cnt_reg <= phase_cnt_reg - 8'h01;
          end
          if (!i_dw_read_busy && !test_hold && !command_word_register) begin
            aux_state_reg <= aux_readout_pkg::AUX_LOAD;
            o_chan_sel <= addr_word_reg[`ADDR_CHAN_LSB +: 5];
            o_use_latched <= i_readout_armed && !i_readout_done
                             && !switch_reg.latching_bypass;
            o_veto <= switch_reg.veto_on_bus_read;
            veto_cnt_reg <= 8'(`VETO_CYC - 1);
          end
        end
        aux_readout_pkg::AUX_LOAD: begin
          if (phase_cnt_reg != 8'h00) begin
            phase_cnt_reg <= phase_cnt_reg - 8'h01;
          end
          if (veto_cnt_reg != 8'h00) veto_cnt_reg <= veto_cnt_reg - 8'h01;
          else o_veto <= 1'b0;
          if (phase_cnt_reg == 8'h00 && veto_cnt_reg == 8'h00) begin
            aux_state_reg <= aux_readout_pkg::AUX_DRIVE;
            bus_reg.lines_n <= ~i_chan_value;
            bus_reg.lines_oe <= 1'b1;
            bus_reg.strobe_oe <= 1'b1;
            phase_cnt_reg <= 8'(`STROBE_CYC - 1);
          end
        end
        aux_readout_pkg::AUX_DRIVE: begin
          if (phase_cnt_reg != 8'h00) begin
            phase_cnt_reg <= phase_cnt_reg - 8'h01;
          end else begin
            bus_reg <= '0;
            aux_state_reg <= aux_readout_pkg::AUX_IDLE;
          end
        end
      endcase
    end
  end

  // Pin data and enables straight from the bus flops
  assign o_shared_bus_lines_n = bus_reg.lines_n;
  assign o_shared_bus_lines_oe = bus_reg.lines_oe;
  assign o_data_valid_strobe_oe = bus_reg.strobe_oe;
  assign o_data_valid_strobe_n = 1'b0; // Open collector: only ever pulls low

endmodule

// *** sim/aux_readout_sva.sv ***
// Assertion checker for the auxiliary readout port timing
`timescale 1ns/1ps
// ****************************************
// Checker
// ****************************************
module aux_readout_sva (
  input wire logic i_clk_sys, // Clock
  input wire logic i_rst_n, // Reset, active low
  input wire logic i_address_strobe_n, // Address strobe
  input wire logic i_fn_test_lam, // Test function
  input wire logic i_fn_clear_lam, // Clear function
  input wire logic i_fn_enable_lam, // Enable function
  input wire logic i_fn_disable_lam, // Disable function
  input wire logic [23:0] o_shared_bus_lines_n, // Data out
  input wire logic o_shared_bus_lines_oe, // Data enable
  input wire logic o_data_valid_strobe_oe, // Data strobe enable
  input wire logic o_veto, // Counting inhibit
  input wire logic o_load_req, // Load pulse
  input wire logic o_clear_req, // Clear pulse
  input wire logic o_lam, // Look-at-me
  input wire logic o_q // Q answer
);
  logic [7:0] dcnt_reg;
  logic [7:0] vcnt_reg;
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);
  // Counts cycles the data strobe has stood
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) dcnt_reg <= 8'h00;
    else dcnt_reg <= o_data_valid_strobe_oe ? dcnt_reg + 8'h01 : 8'h00;
  end
  // Counts cycles the veto has stood
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) vcnt_reg <= 8'h00;
    else vcnt_reg <= o_veto ? vcnt_reg + 8'h01 : 8'h00;
  end
  // Strobe width 500 ns within 50 ns, data in phase and steady
  strobe_width_a: assert property ($fell(o_data_valid_strobe_oe) |->
    dcnt_reg inside {[8'h71:8'h89]}) else $error("data strobe width wrong");
  strobe_max_a: assert property (dcnt_reg <= 8'h89)
    else $error("data strobe too long");
  strobe_phase_a: assert property (o_shared_bus_lines_oe == o_data_valid_strobe_oe)
    else $error("data and strobe out of phase");
  data_stable_a: assert property (o_shared_bus_lines_oe && $past(o_shared_bus_lines_oe) |->
    $stable(o_shared_bus_lines_n)) else $error("data changed while driven");
  resp_delay_a: assert property ($rose(o_shared_bus_lines_oe) |->
    i_address_strobe_n && $past(i_address_strobe_n, 125)) else $error("answer too early");
  veto_width_a: assert property ($fell(o_veto) |-> vcnt_reg == 8'h32)
    else $error("veto width wrong");
  load_clear_a: assert property (o_load_req |=> o_clear_req && !o_load_req)
    else $error("clear did not follow load");
  clear_cause_a: assert property (o_clear_req |-> $past(o_load_req))
    else $error("clear without load");
  q_answer_a: assert property (i_fn_clear_lam || i_fn_enable_lam || i_fn_disable_lam |=> o_q)
    else $error("no Q to function");
  q_idle_a: assert property (!(i_fn_test_lam || i_fn_clear_lam || i_fn_enable_lam ||
    i_fn_disable_lam) |=> !o_q) else $error("Q without function");
  lam_off_a: assert property (i_fn_disable_lam |-> ##2 !o_lam)
    else $error("look-at-me not masked");
endmodule
bind aux_readout aux_readout_sva chk (.*);

// *** sim/aux_bus_master.sv ***
// Bus master model reading channels over the auxiliary bus
`timescale 1ns/1ps
module aux_bus_master (
  input wire logic i_clk_sys, // Clock
  input wire logic i_dry_line, // Data strobe line, low asserted
  input wire logic [23:0] i_data_line, // Data lines, negative logic
  output logic [8:0] o_addr_n, // Address lines, negative logic
  output logic o_strobe_n // Address strobe, active low
);
  // Idle bus lines float up to logic zero
  initial {o_addr_n, o_strobe_n} = 10'h3FF;
  // One addressed read; ok stays low when nobody answers
  task automatic rd(input logic [3:0] m, input logic [4:0] c, output logic [23:0] d,
      output logic ok, output int lat);
    int k = 0;
    ok = 1'b0;
    lat = 0;
    @(posedge i_clk_sys);
    o_addr_n <= ~{m, c};
    o_strobe_n <= 1'b0;
    repeat (75) @(posedge i_clk_sys);
    o_addr_n <= 9'h1FF;
    o_strobe_n <= 1'b1;
    while (!ok && lat < 5000) begin
      @(posedge i_clk_sys);
      lat++;
      ok = (i_dry_line === 1'b0);
    end
    d = ~i_data_line;
    while (ok && i_dry_line === 1'b0 && k < 300) begin
      @(posedge i_clk_sys);
      k++;
    end
  endtask
endmodule

// *** sim/testbench.sv ***
// Self-checking testbench of the auxiliary readout block
`timescale 1ns/1ps
module testbench;
  logic i_clk_sys = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00;
  logic [31:0] i_wdata = 32'h0, i_chan_bit16 = 32'h0, i_chan_bit24 = 32'h0, o_rdata, d;
  logic [3:0] i_wstrb = 4'hF;
  logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
  logic i_readout_armed = 1'b0, i_readout_done = 1'b0, i_dw_read_busy = 1'b0;
  logic [8:0] pls = 9'h000, i_shared_bus_lines_n;
  logic i_dw_init, i_readout_init, i_readout_request, i_s2_read, i_test_start;
  logic i_fn_test_lam, i_fn_clear_lam, i_fn_enable_lam, i_fn_disable_lam;
  logic [23:0] i_chan_value, o_shared_bus_lines_n, data_line, dd;
  logic i_address_strobe_n, dry_line, ok;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_use_latched, o_veto;
  logic o_load_req, o_clear_req, o_lam, o_q, o_shared_bus_lines_oe;
  logic o_data_valid_strobe_n, o_data_valid_strobe_oe;
  logic [1:0] o_bresp, o_rresp, r;
  logic [4:0] o_chan_sel;
  int bad_count = 0, compares = 0, n, lat, lc;
  // Rows: module, channel, armed, bypass, answer expected
  localparam logic [11:0] rows [5] = '{12'hA01, 12'hAF9, 12'hA2D, 12'hA4F, 12'h338};
  // Pulse inputs share one vector
  assign {i_fn_disable_lam, i_fn_enable_lam, i_fn_clear_lam, i_fn_test_lam, i_test_start,
    i_s2_read, i_readout_request, i_readout_init, i_dw_init} = pls;
  // Scaler core: value names its channel and source
  assign i_chan_value = {3'h5, o_use_latched, 15'h0000, o_chan_sel};
  // Released lines are pulled up
  assign dry_line = o_data_valid_strobe_oe ? o_data_valid_strobe_n : 1'b1;
  assign data_line = o_shared_bus_lines_oe ? o_shared_bus_lines_n : 24'hFFFFFF;
  always #2 i_clk_sys = ~i_clk_sys;
  aux_readout dut (.*);
  aux_bus_master bm (.i_clk_sys, .i_dry_line(dry_line), .i_data_line(data_line),
    .o_addr_n(i_shared_bus_lines_n), .o_strobe_n(i_address_strobe_n));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic guard();
    if (n >= 100) begin
      bad_count++;
      $display("MISMATCH register bus expected answer seen none");
      finish_test();
    end
  endtask
  task automatic pulse(input int k);
    @(posedge i_clk_sys);
    pls[k] <= 1'b1;
    @(posedge i_clk_sys);
    pls <= 9'h000;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    n = 0;
    @(posedge i_clk_sys);
    i_awaddr <= a;
    i_wdata <= v;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    while ((aw || w) && n < 100) begin
      @(posedge i_clk_sys);
      n++;
      if (aw && o_awready === 1'b1) i_awvalid <= 1'b0;
      if (aw && o_awready === 1'b1) aw = 1'b0;
      if (w && o_wready === 1'b1) i_wvalid <= 1'b0;
      if (w && o_wready === 1'b1) w = 1'b0;
    end
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (o_bvalid !== 1'b1 && n < 100);
    r = o_bresp;
    i_bready <= 1'b0;
    guard();
  endtask
  task automatic axi_rd(input logic [7:0] a);
    n = 0;
    @(posedge i_clk_sys);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (o_arready !== 1'b1 && n < 100);
    i_arvalid <= 1'b0;
    while (o_rvalid !== 1'b1 && n < 100) begin
      @(posedge i_clk_sys);
      n++;
    end
    d = o_rdata;
    r = o_rresp;
    i_rready <= 1'b0;
    guard();
  endtask
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    repeat (10) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    axi_rd(8'h04);
    chk("switch reset", d, 32'h0);
    chk("lam reset", o_lam, 1'b0);
    axi_rd(8'h0C);
    chk("unmapped resp", r, 2'h2);
    $display("reset test done");
    for (int i = 0; i < 5; i++) begin
      axi_wr(8'h04, 32'h540 | (rows[i][1] << 5));
      i_readout_armed <= rows[i][2];
      bm.rd(rows[i][11:8], rows[i][7:3], dd, ok, lat);
      chk("aux answer", ok, rows[i][0]);
      if (rows[i][0]) begin
        chk("aux data", dd, {3'h5, rows[i][2] & ~rows[i][1], 15'h0, rows[i][7:3]});
        chk("aux delay", lat inside {[125:225]}, 1'b1);
      end
    end
    $display("table test done");
    i_readout_armed <= 1'b0;
    axi_wr(8'h00, 32'h1);
    chk("write resp", r, 2'h0);
    bm.rd(4'hA, 5'h01, dd, ok, lat);
    chk("suspended answer", ok, 1'b0);
    pulse(0);
    axi_rd(8'h00);
    chk("suspend after init", d, 32'h0);
    axi_wr(8'h04, 32'h540);
    repeat (200) @(posedge i_clk_sys);
    bm.rd(4'hA, 5'h01, dd, ok, lat);
    chk("resumed answer", ok, 1'b1);
    pulse(4);
    bm.rd(4'hA, 5'h03, dd, ok, lat);
    chk("test hold", ok && lat > 3100, 1'b1);
    i_dw_read_busy <= 1'b1;
    fork
      bm.rd(4'hA, 5'h02, dd, ok, lat);
      begin
        repeat (300) @(posedge i_clk_sys);
        i_dw_read_busy <= 1'b0;
      end
    join
    chk("busy delay", ok && lat > 200, 1'b1);
    $display("hold test done");
    axi_wr(8'h04, 32'h544);
    pulse(7);
    i_chan_bit16 <= 32'h80;
    repeat (3) @(posedge i_clk_sys);
    chk("lam overflow", o_lam, 1'b1);
    i_chan_bit16 <= 32'h0;
    i_chan_bit24 <= 32'h1;
    repeat (3) @(posedge i_clk_sys);
    chk("lam narrow", o_lam, 1'b0);
    axi_wr(8'h04, 32'h545);
    repeat (3) @(posedge i_clk_sys);
    chk("lam wide", o_lam, 1'b1);
    i_chan_bit24 <= 32'h0;
    axi_wr(8'h04, 32'h542);
    i_chan_bit16 <= 32'h80000000;
    lc = 0;
    repeat (8) begin
      @(posedge i_clk_sys);
      if (o_load_req === 1'b1) lc++;
      if (o_clear_req === 1'b1) lc++;
    end
    chk("load clear pulses", lc, 32'h2);
    i_chan_bit16 <= 32'h0;
    axi_wr(8'h04, 32'h548);
    i_readout_armed <= 1'b1;
    pulse(1);
    repeat (3) @(posedge i_clk_sys);
    chk("lam data valid", o_lam, 1'b1);
    pulse(3);
    repeat (3) @(posedge i_clk_sys);
    chk("lam after read", o_lam, 1'b0);
    repeat (130) @(posedge i_clk_sys);
    chk("lam next channel", o_lam, 1'b1);
    i_readout_done <= 1'b1;
    pulse(3);
    repeat (140) @(posedge i_clk_sys);
    chk("lam last read", o_lam, 1'b0);
    $display("lam test done");
    axi_wr(8'h04, 32'h550);
    pulse(6);
    @(posedge i_clk_sys);
    chk("q clear", o_q, 1'b1);
    pulse(2);
    repeat (3) @(posedge i_clk_sys);
    chk("lam readout request", o_lam, 1'b1);
    pulse(5);
    @(posedge i_clk_sys);
    chk("q test", o_q, 1'b1);
    pulse(8);
    repeat (3) @(posedge i_clk_sys);
    chk("lam disabled", o_lam, 1'b0);
    $display("function test done");
    finish_test();
  end
endmodule
